// ===== core/dag_params.svh
// Constants of the data operand address generator
`ifndef DAG_PARAMS_SVH
`define DAG_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DAG_AW 12
`define DAG_PCW 20
`define DAG_NPAIR 3

// ----------------------------------------------------------------
// Special register map of the pointer pairs
// ----------------------------------------------------------------
`define DAG_IND_BASE 12'hFEF
`define DAG_IND_ONE 12'hFE7
`define DAG_PAIR_STEP 12'h008
`define DAG_OFS_POST_INCREMENT_PORT 12'h001
`define DAG_OFS_POST_DECREMENT_PORT 12'h002
`define DAG_OFS_PRE_INCREMENT_PORT 12'h003
`define DAG_OFS_OFFSET_BY_WORKING_PORT 12'h004
`define DAG_OFS_PTR_HI 12'h005
`define DAG_OFS_PTR_LO 12'h006

// ----------------------------------------------------------------
// Access bank and reset values
// ----------------------------------------------------------------
`define DAG_ACC_SPLIT 8'h60
`define DAG_IDX_MAX 8'h5F
`define DAG_TOP_BANK 4'hF
`define DAG_LOW_BANK 4'h0
`define DAG_RD_VIRT 8'h00
`define DAG_HI_UNUSED 4'h0
`define DAG_PTR_RST 12'h000
`define DAG_BYTE_RST 8'h00
`define DAG_PC_RST 20'h00000
`define DAG_ADDR_RST 12'h000

`endif

// ===== core/dag_pkg.sv
// Types of the data operand address generator
`include "dag_params.svh"

package dag_pkg;

  // ----------------------------------------------------------------
  // Instruction classes and port kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DAG_INHERENT, DAG_LITERAL, DAG_BRANCH, DAG_DIRECT, DAG_FULL
  } dag_class_t;

  typedef enum logic [2:0] {
    DAG_K_NONE, DAG_K_INDF, DAG_K_POST_INCREMENT_PORT, DAG_K_POST_DECREMENT_PORT,
    DAG_K_PRE_INCREMENT_PORT, DAG_K_OFFSET_BY_WORKING_PORT, DAG_K_PTR_HI, DAG_K_PTR_LO
  } dag_kind_t;

  typedef enum logic [1:0] {
    DAG_SRC_MEM, DAG_SRC_HELD, DAG_SRC_ZERO
  } dag_src_t;

  typedef struct packed {
    logic [1:0] pair;
    dag_kind_t kind;
  } dag_hit_t;

  // ----------------------------------------------------------------
  // Module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`DAG_AW-1:0] ptr;
  } dag_ptr_state_t;

  typedef struct packed {
    logic s1_vld;
    logic s1_rd;
    logic s1_wr;
    logic [`DAG_AW-1:0] s1_addr;
    logic [7:0] s1_wdata;
    dag_src_t s1_src;
    logic [7:0] s1_held;
    logic done;
    logic [7:0] rdata;
    logic [7:0] lit;
    logic [`DAG_PCW-1:0] target;
    logic dest_w;
  } dag_state_t;

endpackage : dag_pkg

// ===== core/dag_ptr_pair.sv
// One 12-bit pointer pair with auto update
`timescale 1ns/1ps
`include "dag_params.svh"

module dag_ptr_pair
  import dag_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] wdata_i,
  input wire logic inc_i,
  input wire logic dec_i,
  output logic [`DAG_AW-1:0] ptr_o
);

  dag_ptr_state_t st_r;
  dag_ptr_state_t st_nxt;

  // ----------------------------------------------------------------
  // Next pointer value
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (wr_lo_i || wr_hi_i) begin
      // Store wins over any automatic update
      if (wr_lo_i) begin
        st_nxt.ptr[7:0] = wdata_i;
      end
      if (wr_hi_i) begin
        st_nxt.ptr[11:8] = wdata_i[3:0];
      end
    end else if (inc_i) begin
      st_nxt.ptr = st_r.ptr + 12'h001;
    end else if (dec_i) begin
      st_nxt.ptr = st_r.ptr - 12'h001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r <= '{ptr: `DAG_PTR_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ptr_o = st_r.ptr;

endmodule : dag_ptr_pair

// ===== core/dag_top.sv
// Data operand address generator of the core
// Contract
// - Inherent: no operand; literal: constant from opcode
// - Call and jump carry 20-bit target
// - Low opcode byte is direct address field
// - Access bit one: bank register joins field
// - Access bit zero: fixed access bank used
// - Full move uses 12-bit addresses, no bank
// - Destination bit picks source register or working
// - Three 12-bit pointer pairs, top nibble unused
// - Plain port uses pointer, leaves it unchanged
// - Indirect uses full pointer, no bank bits
// - Post-decrement: access, then pointer minus one
// - Post-increment: access, then pointer plus one
// - Pre-increment: pointer plus one, then access
// - Offset port: pointer plus signed working value
// - Pointer carry and borrow cross both bytes
// - Pointer updates touch no status flags
// - Pointer on virtual port: read zero, no write
// - Indirect write to its own pointer skips auto update
// - Pointer bytes readable, writable as direct registers
// - Extended set keeps pointers zero, one unchanged
// - Extended, access zero, field low: pointer two
// - Fields 60h to FFh map to top bank
`timescale 1ns/1ps
`include "dag_params.svh"

module dag_top
  import dag_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ext_set_i,
  input wire logic req_i,
  input wire dag_class_t class_i,
  input wire logic [7:0] field_i,
  input wire logic acc_sel_i,
  input wire logic dest_sel_i,
  input wire logic [3:0] bank_i,
  input wire logic [7:0] work_i,
  input wire logic [7:0] literal_i,
  input wire logic [`DAG_PCW-1:0] target_i,
  input wire logic [`DAG_AW-1:0] full_addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic upd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [`DAG_AW-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic [7:0] lit_o,
  output logic [`DAG_PCW-1:0] target_o,
  output logic dest_w_o,
  output logic [`DAG_AW-1:0] ptr_zero_o,
  output logic [`DAG_AW-1:0] ptr_one_o,
  output logic [`DAG_AW-1:0] ptr_two_o
);

  // ----------------------------------------------------------------
  // Address classification
  // ----------------------------------------------------------------
  function automatic dag_hit_t dag_decode(input logic [11:0] a);
    dag_hit_t h;
    logic [11:0] b;
    h.pair = 2'h0;
    h.kind = DAG_K_NONE;
    for (int n = 0; n < `DAG_NPAIR; n++) begin
      b = `DAG_IND_BASE - (12'(n) * `DAG_PAIR_STEP);
      if (a == b) begin
        h = '{pair: 2'(n), kind: DAG_K_INDF};
      end else if (a == b - `DAG_OFS_POST_INCREMENT_PORT) begin
        h = '{pair: 2'(n), kind: DAG_K_POST_INCREMENT_PORT};
      end else if (a == b - `DAG_OFS_POST_DECREMENT_PORT) begin
        h = '{pair: 2'(n), kind: DAG_K_POST_DECREMENT_PORT};
      end else if (a == b - `DAG_OFS_PRE_INCREMENT_PORT) begin
        h = '{pair: 2'(n), kind: DAG_K_PRE_INCREMENT_PORT};
      end else if (a == b - `DAG_OFS_OFFSET_BY_WORKING_PORT) begin
        h = '{pair: 2'(n), kind: DAG_K_OFFSET_BY_WORKING_PORT};
      end else if (a == b - `DAG_OFS_PTR_HI) begin
        h = '{pair: 2'(n), kind: DAG_K_PTR_HI};
      end else if (a == b - `DAG_OFS_PTR_LO) begin
        h = '{pair: 2'(n), kind: DAG_K_PTR_LO};
      end
    end
    return h;
  endfunction : dag_decode

  function automatic logic dag_is_virt(input dag_kind_t k);
    return (k == DAG_K_INDF) || (k == DAG_K_POST_INCREMENT_PORT) ||
           (k == DAG_K_POST_DECREMENT_PORT) || (k == DAG_K_PRE_INCREMENT_PORT) ||
           (k == DAG_K_OFFSET_BY_WORKING_PORT);
  endfunction : dag_is_virt

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dag_state_t st_r;
  dag_state_t st_nxt;

  logic [`DAG_AW-1:0] ptr_q [`DAG_NPAIR];
  logic [`DAG_NPAIR-1:0] ptr_wlo;
  logic [`DAG_NPAIR-1:0] ptr_whi;
  logic [`DAG_NPAIR-1:0] ptr_inc;
  logic [`DAG_NPAIR-1:0] ptr_dec;

  logic is_data;
  logic [`DAG_AW-1:0] dir_addr;
  logic [`DAG_AW-1:0] base_addr;
  logic [`DAG_AW-1:0] eff_addr;
  logic [`DAG_AW-1:0] sel_ptr;
  logic indirect;
  logic virt_tgt;
  logic ptr_tgt;
  logic same_pair;
  dag_hit_t hit_base;
  dag_hit_t hit_eff;
  dag_hit_t hit_fin;

  // ----------------------------------------------------------------
  // Pointer pairs
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `DAG_NPAIR; g++) begin : g_pair
    dag_ptr_pair u_pair (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_lo_i(ptr_wlo[g]),
      .wr_hi_i(ptr_whi[g]),
      .wdata_i(wdata_i),
      .inc_i(ptr_inc[g]),
      .dec_i(ptr_dec[g]),
      .ptr_o(ptr_q[g])
    );
  end

  // ----------------------------------------------------------------
  // Direct address forming
  // ----------------------------------------------------------------
  always_comb begin
    if (acc_sel_i) begin
      dir_addr = {bank_i, field_i};
    end else if (ext_set_i && (field_i <= `DAG_IDX_MAX)) begin
      dir_addr = ptr_q[2] + {4'h0, field_i};
    end else if (field_i >= `DAG_ACC_SPLIT) begin
      dir_addr = {`DAG_TOP_BANK, field_i};
    end else begin
      dir_addr = {`DAG_LOW_BANK, field_i};
    end
  end

  always_comb begin
    case (class_i)
      DAG_DIRECT: begin
        base_addr = dir_addr;
      end
      DAG_FULL: begin
        base_addr = full_addr_i;
      end
      default: begin
        base_addr = `DAG_ADDR_RST;
      end
    endcase
  end

  assign is_data = req_i && (rd_i || wr_i) &&
                   ((class_i == DAG_DIRECT) || (class_i == DAG_FULL));

  // ----------------------------------------------------------------
  // Indirect resolution
  // ----------------------------------------------------------------
  // Port hit on the direct or full address
  assign hit_base = dag_decode(base_addr);
  assign indirect = dag_is_virt(hit_base.kind);
  assign sel_ptr = ptr_q[hit_base.pair];

  // Bank and access bit play no part once a port is hit
  always_comb begin
    case (hit_base.kind)
      DAG_K_PRE_INCREMENT_PORT: begin
        eff_addr = sel_ptr + 12'h001;
      end
      DAG_K_OFFSET_BY_WORKING_PORT: begin
        eff_addr = sel_ptr + {{4{work_i[7]}}, work_i};
      end
      DAG_K_INDF, DAG_K_POST_INCREMENT_PORT, DAG_K_POST_DECREMENT_PORT: begin
        eff_addr = sel_ptr;
      end
      default: begin
        eff_addr = base_addr;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Final target of an indirect access
  // ----------------------------------------------------------------
  assign hit_eff = dag_decode(eff_addr);
  assign hit_fin = indirect ? hit_eff : hit_base;
  assign virt_tgt = indirect && dag_is_virt(hit_eff.kind);
  assign ptr_tgt = (hit_fin.kind == DAG_K_PTR_HI) ||
                   (hit_fin.kind == DAG_K_PTR_LO);
  assign same_pair = indirect && (hit_fin.pair == hit_base.pair);

  // ----------------------------------------------------------------
  // Pointer control
  // ----------------------------------------------------------------
  // Updates go straight to the pairs, never to the status flags
  always_comb begin
    ptr_wlo = '0;
    ptr_whi = '0;
    ptr_inc = '0;
    ptr_dec = '0;
    // Store into a pointer byte, direct or through a port
    if (is_data && wr_i && ptr_tgt && !virt_tgt) begin
      if (hit_fin.kind == DAG_K_PTR_LO) begin
        ptr_wlo[hit_fin.pair] = 1'h1;
      end else begin
        ptr_whi[hit_fin.pair] = 1'h1;
      end
    end
    // A pointer aimed at a port neither stores nor steps
    if (is_data && indirect && upd_i && !virt_tgt &&
        !(wr_i && ptr_tgt && same_pair)) begin
      case (hit_base.kind)
        DAG_K_POST_INCREMENT_PORT, DAG_K_PRE_INCREMENT_PORT: begin
          ptr_inc[hit_base.pair] = 1'h1;
        end
        DAG_K_POST_DECREMENT_PORT: begin
          ptr_dec[hit_base.pair] = 1'h1;
        end
        DAG_K_INDF: begin
          ptr_inc[hit_base.pair] = 1'h0;
        end
        DAG_K_OFFSET_BY_WORKING_PORT: begin
          ptr_inc[hit_base.pair] = 1'h0;
        end
        default: begin
          ptr_dec[hit_base.pair] = 1'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pipeline state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1_vld = req_i;
    st_nxt.s1_rd = 1'h0;
    st_nxt.s1_wr = 1'h0;
    st_nxt.s1_src = DAG_SRC_ZERO;
    if (is_data) begin
      st_nxt.s1_addr = indirect ? eff_addr : base_addr;
      st_nxt.s1_wdata = wdata_i;
      // Final targets on a port or a pointer byte never strobe the data memory
      if (virt_tgt) begin
        st_nxt.s1_src = DAG_SRC_ZERO;
      end else if (ptr_tgt) begin
        st_nxt.s1_src = DAG_SRC_HELD;
        if (hit_fin.kind == DAG_K_PTR_LO) begin
          st_nxt.s1_held = ptr_q[hit_fin.pair][7:0];
        end else begin
          st_nxt.s1_held = {`DAG_HI_UNUSED,
                            ptr_q[hit_fin.pair][11:8]};
        end
      end else begin
        st_nxt.s1_src = DAG_SRC_MEM;
        st_nxt.s1_rd = rd_i;
        st_nxt.s1_wr = wr_i;
      end
    end
    if (req_i) begin
      case (class_i)
        DAG_LITERAL: begin
          st_nxt.lit = literal_i;
        end
        DAG_BRANCH: begin
          st_nxt.target = target_i;
        end
        DAG_DIRECT: begin
          st_nxt.dest_w = !dest_sel_i;
        end
        default: begin
          st_nxt.dest_w = st_r.dest_w;
        end
      endcase
    end
    // Second stage: result and completion one cycle later
    st_nxt.done = st_r.s1_vld;
    if (st_r.s1_vld) begin
      case (st_r.s1_src)
        DAG_SRC_MEM: begin
          st_nxt.rdata = st_r.s1_rd ? mem_rdata_i : `DAG_BYTE_RST;
        end
        DAG_SRC_HELD: begin
          st_nxt.rdata = st_r.s1_held;
        end
        default: begin
          st_nxt.rdata = `DAG_RD_VIRT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r <= '{s1_vld: 1'h0, s1_rd: 1'h0, s1_wr: 1'h0,
                s1_addr: `DAG_ADDR_RST, s1_wdata: `DAG_BYTE_RST,
                s1_src: DAG_SRC_ZERO, s1_held: `DAG_BYTE_RST,
                done: 1'h0, rdata: `DAG_BYTE_RST,
                lit: `DAG_BYTE_RST, target: `DAG_PC_RST,
                dest_w: 1'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_addr_o = st_r.s1_addr;
  assign mem_rd_o = st_r.s1_vld && st_r.s1_rd;
  assign mem_wr_o = st_r.s1_vld && st_r.s1_wr;
  assign mem_wdata_o = st_r.s1_wdata;
  assign done_o = st_r.done;
  assign rdata_o = st_r.rdata;
  assign lit_o = st_r.lit;
  assign target_o = st_r.target;
  assign dest_w_o = st_r.dest_w;
  assign ptr_zero_o = ptr_q[0];
  assign ptr_one_o = ptr_q[1];
  assign ptr_two_o = ptr_q[2];

endmodule : dag_top

// ===== test/dag_monitor.sv
// Assertion checker of the data operand address generator
`timescale 1ns/1ps
`include "dag_params.svh"

module dag_monitor
  import dag_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ext_set_i,
  input wire logic req_i,
  input wire dag_class_t class_i,
  input wire logic [7:0] field_i,
  input wire logic acc_sel_i,
  input wire logic dest_sel_i,
  input wire logic [3:0] bank_i,
  input wire logic [7:0] literal_i,
  input wire logic [`DAG_PCW-1:0] target_i,
  input wire logic [`DAG_AW-1:0] full_addr_i,
  input wire logic rd_i,
  input wire logic upd_i,
  input wire logic [`DAG_AW-1:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic done_o,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] lit_o,
  input wire logic [`DAG_PCW-1:0] target_o,
  input wire logic dest_w_o,
  input wire logic [`DAG_AW-1:0] ptr_zero_o,
  input wire logic [`DAG_AW-1:0] ptr_two_o
);
  // ----------------------------------------------------------------
  // Completion timing, address forming, operand capture and pointer updates
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_done_timing: assert property (req_i |-> ##2 done_o)
    else $error("done missing two cycles after request");
  chk_bank_join: assert property (
    req_i && class_i == DAG_DIRECT && acc_sel_i && rd_i && bank_i != 4'hF
    |=> mem_rd_o && mem_addr_o == {$past(bank_i), $past(field_i)})
    else $error("bank address wrong");
  chk_access_top: assert property (
    req_i && class_i == DAG_DIRECT && !acc_sel_i && rd_i
    && field_i >= 8'h60 && field_i < 8'hD9
    |=> mem_rd_o && mem_addr_o == {4'hF, $past(field_i)})
    else $error("top access bank address wrong");
  chk_access_low: assert property (
    !ext_set_i && req_i && rd_i && class_i == DAG_DIRECT && !acc_sel_i
    && field_i < 8'h60 |=> mem_addr_o == {4'h0, $past(field_i)})
    else $error("low access bank address wrong");
  chk_full_move: assert property (
    req_i && class_i == DAG_FULL && rd_i && full_addr_i[11:8] != 4'hF
    |=> mem_addr_o == $past(full_addr_i))
    else $error("full move address wrong");
  chk_lit_take: assert property (
    req_i && class_i == DAG_LITERAL |=> lit_o == $past(literal_i))
    else $error("literal not taken");
  chk_branch_take: assert property (
    req_i && class_i == DAG_BRANCH |=> target_o == $past(target_i))
    else $error("branch target not taken");
  chk_dest_pick: assert property (
    req_i && class_i == DAG_DIRECT |=> dest_w_o == !$past(dest_sel_i))
    else $error("destination select wrong");
  chk_post_inc: assert property (
    req_i && class_i == DAG_DIRECT && !acc_sel_i && field_i == 8'hEE
    && rd_i && upd_i && ptr_zero_o[11:8] < 4'hE
    |=> ptr_zero_o == $past(ptr_zero_o) + 12'h001)
    else $error("post increment wrong");
  chk_post_dec: assert property (
    req_i && class_i == DAG_DIRECT && !acc_sel_i && field_i == 8'hED
    && rd_i && upd_i && ptr_zero_o[11:8] < 4'hE
    |=> ptr_zero_o == $past(ptr_zero_o) - 12'h001)
    else $error("post decrement wrong");
  chk_pre_addr: assert property (
    req_i && class_i == DAG_DIRECT && !acc_sel_i && field_i == 8'hEC
    && rd_i && ptr_zero_o[11:8] < 4'hE
    |=> mem_addr_o == $past(ptr_zero_o) + 12'h001)
    else $error("pre increment address wrong");
  chk_plain_hold: assert property (
    req_i && class_i == DAG_DIRECT && !acc_sel_i && field_i == 8'hEF
    && ptr_zero_o[11:8] < 4'hE |=> $stable(ptr_zero_o) ##1 done_o)
    else $error("plain port moved pointer");
  chk_virt_zero: assert property (
    req_i && class_i == DAG_DIRECT && rd_i && !acc_sel_i && field_i == 8'hEF
    && ptr_zero_o == 12'hFE7 |=> !mem_rd_o ##1 rdata_o == 8'h00)
    else $error("virtual port read not zero");
  chk_index_two: assert property (
    ext_set_i && req_i && rd_i && class_i == DAG_DIRECT && !acc_sel_i
    && field_i <= 8'h5F && ptr_two_o[11:8] < 4'hE
    |=> mem_addr_o == $past(ptr_two_o) + {4'h0, $past(field_i)})
    else $error("indexed address wrong");
endmodule : dag_monitor

bind dag_top dag_monitor u_mon (.*);

// ===== test/dag_mem_model.sv
// Data memory model facing the address generator
`timescale 1ns/1ps

module dag_mem_model (
  input wire logic clk_sys_i,
  input wire logic [11:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] ram [4096];
  logic [7:0] last = 8'h00;

  initial begin
    for (int i = 0; i < 4096; i++) begin
      ram[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
    end
  end

  always @(posedge clk_sys_i) begin
    if (wr_i) ram[addr_i] <= wdata_i;
    if (rd_i) last <= rdata_o;
  end

  // Idle bus shows the inverse of the last byte
  assign rdata_o = rd_i ? ram[addr_i] : ~last;
endmodule : dag_mem_model

// ===== test/dag_top_bench.sv
// Self-checking bench of the data operand address generator
`timescale 1ns/1ps
`include "dag_params.svh"

module dag_top_bench
  import dag_pkg::*;
;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, ext_set_i = 1'b0, req_i = 1'b0;
  dag_class_t class_i = DAG_INHERENT;
  logic [7:0] field_i = 8'h00, work_i = 8'h00, literal_i = 8'h00;
  logic [7:0] wdata_i = 8'h00, mem_rdata_i, mem_wdata_o, rdata_o, lit_o;
  logic acc_sel_i = 1'b0, dest_sel_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0;
  logic upd_i = 1'b0, mem_rd_o, mem_wr_o, done_o, dest_w_o, s_rd, s_wr;
  logic [3:0] bank_i = 4'h0, t_bank = 4'h0;
  logic [19:0] target_i = 20'h00000, target_o, t_tgt = 20'h00000;
  logic [11:0] full_addr_i = 12'h000, t_full = 12'h000, s_addr;
  logic [11:0] mem_addr_o, ptr_zero_o, ptr_one_o, ptr_two_o;
  logic [7:0] t_work = 8'h00, t_lit = 8'h00, s_wd;
  logic t_ext = 1'b0, t_dest = 1'b0;
  int fails = 0, tests_run = 0, cyc = 0;

  typedef struct {dag_class_t c; logic a; logic [3:0] b; logic [7:0] f;
    logic [11:0] fa; logic [11:0] ex;} dag_row_t;
  dag_row_t rows [6] = '{
    '{DAG_DIRECT, 1'b1, 4'h2, 8'h34, 12'h000, 12'h234},
    '{DAG_DIRECT, 1'b1, 4'hE, 8'hF0, 12'h000, 12'hEF0},
    '{DAG_DIRECT, 1'b0, 4'h7, 8'h34, 12'h000, 12'h034},
    '{DAG_DIRECT, 1'b0, 4'h7, 8'h5F, 12'h000, 12'h05F},
    '{DAG_DIRECT, 1'b0, 4'h7, 8'h80, 12'h000, 12'hF80},
    '{DAG_FULL, 1'b1, 4'h3, 8'h00, 12'h5A5, 12'h5A5}};

  dag_top u_dut (.*);
  dag_mem_model u_mem (.clk_sys_i, .addr_i(mem_addr_o), .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction : pat

  task automatic chk(input string n, input logic [23:0] e,
    input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic op(input dag_class_t c, input logic [7:0] f,
    input logic a, r, w, u, input logic [7:0] d);
    @(posedge clk_sys_i);
    class_i <= c;
    field_i <= f;
    acc_sel_i <= a;
    rd_i <= r;
    wr_i <= w;
    upd_i <= u;
    wdata_i <= d;
    ext_set_i <= t_ext;
    bank_i <= t_bank;
    work_i <= t_work;
    literal_i <= t_lit;
    target_i <= t_tgt;
    full_addr_i <= t_full;
    dest_sel_i <= t_dest;
    req_i <= 1'b1;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    #1;
    s_addr = mem_addr_o;
    s_rd = mem_rd_o;
    s_wr = mem_wr_o;
    s_wd = mem_wdata_o;
    @(posedge clk_sys_i);
    #1;
    chk("done", 1, done_o);
  endtask : op

  task automatic wr_ptr(input logic [7:0] lo_f, input logic [11:0] v);
    op(DAG_DIRECT, lo_f + 8'h01, 0, 0, 1, 0, {4'h0, v[11:8]});
    op(DAG_DIRECT, lo_f, 0, 0, 1, 0, v[7:0]);
  endtask : wr_ptr

  task automatic end_sim();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk("ptr0", 12'h000, ptr_zero_o);
    foreach (rows[i]) begin
      t_bank = rows[i].b;
      t_full = rows[i].fa;
      op(rows[i].c, rows[i].f, rows[i].a, 1, 0, 0, 8'h00);
      chk("addr", rows[i].ex, s_addr);
      chk("rdata", pat(rows[i].ex), rdata_o);
    end
    t_lit = 8'h3C;
    op(DAG_LITERAL, 8'h00, 0, 0, 0, 0, 8'h00);
    chk("lit", 8'h3C, lit_o);
    op(DAG_INHERENT, 8'h00, 0, 1, 1, 0, 8'h00);
    chk("strobe", 0, s_rd | s_wr);
    t_tgt = 20'hABCDE;
    op(DAG_BRANCH, 8'h00, 0, 0, 0, 0, 8'h00);
    chk("target", 20'hABCDE, target_o);
    t_dest = 1'b1;
    t_bank = 4'h2;
    op(DAG_DIRECT, 8'h40, 1, 0, 1, 0, 8'h5A);
    chk("dest_w", 0, dest_w_o);
    chk("wdata", 9'h15A, {s_wr, s_wd});
    t_dest = 1'b0;
    op(DAG_DIRECT, 8'h40, 1, 1, 0, 0, 8'h00);
    chk("dest_w", 1, dest_w_o);
    chk("readback", 8'h5A, rdata_o);
    op(DAG_DIRECT, 8'hEA, 0, 0, 1, 0, 8'hF1);
    op(DAG_DIRECT, 8'hE9, 0, 0, 1, 0, 8'hFF);
    chk("ptr0", 12'h1FF, ptr_zero_o);
    op(DAG_DIRECT, 8'hEA, 0, 1, 0, 0, 8'h00);
    chk("ptr_hi", 8'h01, rdata_o);
    op(DAG_DIRECT, 8'hEE, 0, 1, 0, 1, 8'h00);
    chk("inc", 24'h1FF200, {s_addr, ptr_zero_o});
    op(DAG_DIRECT, 8'hED, 0, 1, 0, 1, 8'h00);
    chk("dec", 24'h2001FF, {s_addr, ptr_zero_o});
    op(DAG_DIRECT, 8'hEC, 0, 1, 0, 1, 8'h00);
    chk("pre", 24'h200200, {s_addr, ptr_zero_o});
    op(DAG_DIRECT, 8'hEF, 0, 1, 0, 1, 8'h00);
    chk("plain", 24'h200200, {s_addr, ptr_zero_o});
    t_work = 8'hFE;
    op(DAG_DIRECT, 8'hEB, 0, 1, 0, 1, 8'h00);
    chk("offset", 24'h1FE200, {s_addr, ptr_zero_o});
    t_work = 8'h7F;
    op(DAG_DIRECT, 8'hEB, 0, 1, 0, 1, 8'h00);
    chk("offset", 12'h27F, s_addr);
    wr_ptr(8'hE9, 12'hFE7);
    op(DAG_DIRECT, 8'hEF, 0, 1, 0, 0, 8'h00);
    chk("virt_rd", 9'h000, {s_rd, rdata_o});
    op(DAG_DIRECT, 8'hEF, 0, 0, 1, 0, 8'h77);
    chk("virt_wr", 0, s_wr);
    op(DAG_DIRECT, 8'hE9, 0, 0, 1, 0, 8'hE9);
    op(DAG_DIRECT, 8'hED, 0, 0, 1, 1, 8'h55);
    chk("self_wr", 12'hF55, ptr_zero_o);
    wr_ptr(8'hE9, 12'h123);
    t_bank = 4'hF;
    op(DAG_DIRECT, 8'hEF, 1, 1, 0, 0, 8'h00);
    chk("ind_bank", 12'h123, s_addr);
    wr_ptr(8'hD9, 12'h120);
    t_ext = 1'b1;
    op(DAG_DIRECT, 8'h10, 0, 1, 0, 0, 8'h00);
    chk("indexed", 12'h130, s_addr);
    op(DAG_DIRECT, 8'h70, 0, 1, 0, 0, 8'h00);
    chk("ext_top", 12'hF70, s_addr);
    op(DAG_DIRECT, 8'hEF, 0, 1, 0, 0, 8'h00);
    chk("ext_ind", 12'h123, s_addr);
    t_bank = 4'h2;
    op(DAG_DIRECT, 8'h10, 1, 1, 0, 0, 8'h00);
    chk("ext_bank", 12'h210, s_addr);
    wr_ptr(8'hE1, 12'h345);
    chk("ptr1", 12'h345, ptr_one_o);
    op(DAG_DIRECT, 8'hE6, 0, 1, 0, 1, 8'h00);
    chk("ext_inc1", 24'h345346, {s_addr, ptr_one_o});
    // Reset in mid-run
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    chk("rst_ptr", 24'h000000, {ptr_one_o, ptr_two_o});
    chk("rst_out", 0, {done_o, dest_w_o, lit_o});
    op(DAG_DIRECT, 8'h34, 0, 1, 0, 0, 8'h00);
    chk("rst_index", 12'h034, s_addr);
    end_sim();
  end
endmodule : dag_top_bench
